/* File: hdl/status_reg_write_guard.sv */
`timescale 1ns/100ps
module status_reg_write_guard
   import guard_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic wp_pin,
   input wire logic hold_pin,
   input wire nv_cfg_s nv_cfg,
   output guard_state_s guard_state,
   output logic [7:0] quad_and_protect_config,
   output logic pins_as_data,
   output logic hold_pause,
   output logic write_reject,
   output logic quad_cmd_reject
);

   // ************************************************************
   // link side, runs on the serial clock
   // ************************************************************
   logic frame_rst_n;        // frame counter cleared while deselected
   logic [4:0] bit_cnt_ff;   // bits received in frame
   logic [6:0] shift_ff;     // incoming bits
   logic [4:0] nxt_bit_cnt;
   logic [6:0] nxt_shift;
   logic [7:0] opcode_ff;    // held until next frame
   logic [7:0] data_ff;      // held until next frame
   logic cmd_tgl_ff;         // flips when opcode complete
   logic data_tgl_ff;        // flips when data byte complete
   logic [7:0] nxt_opcode;
   logic [7:0] nxt_data;
   logic nxt_cmd_tgl;
   logic nxt_data_tgl;

   assign frame_rst_n = rst_n & ~spi_cs_n;

   // bit counter and shifter next values
   always_comb
   begin
      nxt_shift = {shift_ff[5:0], spi_mosi};
      nxt_bit_cnt = bit_cnt_ff;
      if (bit_cnt_ff != CNT_MAX)
      begin
         nxt_bit_cnt = bit_cnt_ff + 5'h01;
      end
   end

   // frame registers, cleared by deselect since the clock stops
   always_ff @(posedge spi_clk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         bit_cnt_ff <= '0;
         shift_ff <= '0;
      end
      else
      begin
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= nxt_shift;
      end
   end

   // opcode and data capture with event toggles
   always_comb
   begin
      nxt_opcode = opcode_ff;
      nxt_data = data_ff;
      nxt_cmd_tgl = cmd_tgl_ff;
      nxt_data_tgl = data_tgl_ff;
      if (!spi_cs_n && bit_cnt_ff == CMD_LAST)
      begin
         nxt_opcode = {shift_ff, spi_mosi};
         nxt_cmd_tgl = ~cmd_tgl_ff;
      end
      else if (!spi_cs_n && bit_cnt_ff == DATA_LAST)
      begin
         nxt_data = {shift_ff, spi_mosi};
         nxt_data_tgl = ~data_tgl_ff;
      end
   end

   // held words, cleared only by device reset
   always_ff @(posedge spi_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opcode_ff <= '0;
         data_ff <= '0;
         cmd_tgl_ff <= 1'b0;
         data_tgl_ff <= 1'b0;
      end
      else
      begin
         opcode_ff <= nxt_opcode;
         data_ff <= nxt_data;
         cmd_tgl_ff <= nxt_cmd_tgl;
         data_tgl_ff <= nxt_data_tgl;
      end
   end

   // ************************************************************
   // crossings into the core clock
   // ************************************************************
   logic [3:0] sync_out;     // synchronised toggles and pins
   logic cmd_seen_ff;        // last toggle value handled
   logic data_seen_ff;
   logic cmd_evt;            // new opcode this cycle
   logic data_evt;           // new data byte this cycle
   logic wp_high;            // pin high, or pin is a data line
   logic hold_low;           // synchronised shared pin low

   bit_sync #(.WIDTH(4)) u_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      // shared pin enters inverted so the synchroniser's reset value reads as released
      .din({cmd_tgl_ff, data_tgl_ff, wp_pin, ~hold_pin}),
      .dout(sync_out)
   );

   assign cmd_evt = sync_out[3] ^ cmd_seen_ff;
   assign data_evt = sync_out[2] ^ data_seen_ff;
   // [R3] pin ignored in quad
   assign wp_high = guard_state.quad | sync_out[1];
   // no false hold or pin reset right after reset release
   assign hold_low = sync_out[0];

   // ************************************************************
   // guard state
   // ************************************************************
   guard_state_s nxt_state;
   logic load_ff;            // reload from non-volatile copies
   logic nxt_load;
   logic nxt_reject;
   logic nxt_qreject;
   logic nxt_pause;
   logic wr_ok;              // write status allowed now
   logic hw_rst;             // shared pin acting as reset

   // [R6] [R7] [R8] [R9] [R10] [R11] write permission
   assign wr_ok = guard_state.write_enable_latch & ~guard_state.sr_protect_hi & (~guard_state.sr_protect_lo | wp_high);
   // [R2] reset function only outside quad
   assign hw_rst = ~guard_state.quad & guard_state.hold_sel & hold_low;

   // next guard state
   always_comb
   begin
      nxt_state = guard_state;
      nxt_reject = 1'b0;
      nxt_qreject = 1'b0;
      nxt_load = hw_rst || (cmd_evt && opcode_ff == OP_SOFT_RST);
      if (load_ff)
      begin
         nxt_state.lock = nv_cfg.lock;
         nxt_state.quad = nv_cfg.quad;
         nxt_state.hold_sel = nv_cfg.hold_sel;
         nxt_state.write_enable_latch = 1'b0;
         // [R12] [R13] [R14] [R15] reset mapping
         unique case ({nv_cfg.sr_protect_hi, nv_cfg.sr_protect_lo})
            2'b00: {nxt_state.sr_protect_hi, nxt_state.sr_protect_lo} = 2'b00;
            2'b01: {nxt_state.sr_protect_hi, nxt_state.sr_protect_lo} = 2'b01;
            2'b10: {nxt_state.sr_protect_hi, nxt_state.sr_protect_lo} = 2'b00;
            2'b11: {nxt_state.sr_protect_hi, nxt_state.sr_protect_lo} = nv_cfg.lock ? 2'b11 : 2'b01;
         endcase
      end
      else if (data_evt && is_wrsr(opcode_ff))
      begin
         if (wr_ok)
         begin
            nxt_state.write_enable_latch = 1'b0;
            unique case (opcode_ff)
               OP_WRSR1: nxt_state.sr_protect_lo = data_ff[SR_PROTECT_LO_BIT];
               // [R1] [R5] config byte fields
               OP_WRSR2:
               begin
                  nxt_state.quad = data_ff[QE_BIT];
                  nxt_state.sr_protect_hi = data_ff[SR_PROTECT_HI_BIT];
               end
               // [R16] select frozen in quad
               OP_WRSR3:
               begin
                  if (!guard_state.quad)
                  begin
                     nxt_state.hold_sel = data_ff[HOLD_SEL_BIT];
                  end
               end
               default: nxt_state.write_enable_latch = 1'b0;  // fourth byte not held here
            endcase
         end
         else
         begin
            // [R17] refusal leaves state
            nxt_reject = 1'b1;
         end
      end
      else if (cmd_evt)
      begin
         if (opcode_ff == OP_WREN)
         begin
            nxt_state.write_enable_latch = 1'b1;
         end
         else if (opcode_ff == OP_WRDI)
         begin
            nxt_state.write_enable_latch = 1'b0;
         end
         // [R4] quad commands need enable
         nxt_qreject = is_quad_cmd(opcode_ff) & ~guard_state.quad;
      end
      // [R2] hold pauses only outside quad
      nxt_pause = ~nxt_state.quad & ~nxt_state.hold_sel & hold_low;
   end

   // guard registers, reload pending after reset release
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         guard_state <= GUARD_RST;
         load_ff <= 1'b1;
         cmd_seen_ff <= 1'b0;
         data_seen_ff <= 1'b0;
         write_reject <= 1'b0;
         quad_cmd_reject <= 1'b0;
         hold_pause <= 1'b0;
         pins_as_data <= 1'b0;
         quad_and_protect_config <= '0;
      end
      else
      begin
         guard_state <= nxt_state;
         load_ff <= nxt_load;
         cmd_seen_ff <= sync_out[3];
         data_seen_ff <= sync_out[2];
         write_reject <= nxt_reject;
         quad_cmd_reject <= nxt_qreject;
         hold_pause <= nxt_pause;
         // [R3] pins switch to data lines
         pins_as_data <= nxt_state.quad;
         quad_and_protect_config <= {6'h00, nxt_state.quad, nxt_state.sr_protect_hi};
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_wrsr;
      data_evt && is_wrsr(opcode_ff) && !load_ff;
   endsequence

   sequence s_reload_11;
      load_ff && nv_cfg.sr_protect_hi && nv_cfg.sr_protect_lo;
   endsequence

   chk_lockdown_refuse: assert property (s_wrsr and guard_state.sr_protect_hi |=> write_reject && $stable(guard_state)) // [R9]
      else $error("write accepted while locked down");

   chk_hw_protect: assert property (s_wrsr and (guard_state.sr_protect_lo && !guard_state.sr_protect_hi && !wp_high)
      |=> write_reject && $stable(guard_state)) // [R7]
      else $error("write accepted with protect pin low");

   chk_sw_accept: assert property (s_wrsr and (opcode_ff == OP_WRSR2 && guard_state.write_enable_latch &&
      !guard_state.sr_protect_hi && !guard_state.sr_protect_lo) |=> !write_reject &&
      quad_and_protect_config == {6'h00, $past(data_ff[QE_BIT]), $past(data_ff[SR_PROTECT_HI_BIT])}) // [R6]
      else $error("unprotected write not applied");

   chk_hw_unprot: assert property (s_wrsr and (guard_state.write_enable_latch && guard_state.sr_protect_lo && !guard_state.sr_protect_hi &&
      wp_high) |=> !write_reject && !guard_state.write_enable_latch) // [R8]
      else $error("write refused with protect pin high");

   chk_no_wel_refuse: assert property (s_wrsr and !guard_state.write_enable_latch |=> write_reject ##1 !write_reject) // [R17]
      else $error("write without latch not refused once");

   chk_reload_otp: assert property (s_reload_11 and nv_cfg.lock |=> guard_state.sr_protect_hi && guard_state.sr_protect_lo) // [R15]
      else $error("permanent protection lost at reset");

   chk_reload_hw: assert property (s_reload_11 and !nv_cfg.lock |=> !guard_state.sr_protect_hi && guard_state.sr_protect_lo) // [R14]
      else $error("lockdown not turned into hardware protect");

   chk_reload_release: assert property (load_ff && nv_cfg.sr_protect_hi && !nv_cfg.sr_protect_lo
      |=> !guard_state.sr_protect_hi && !guard_state.sr_protect_lo) // [R13]
      else $error("reset lockdown not released");

   chk_quad_gate: assert property (cmd_evt && !data_evt && !load_ff && is_quad_cmd(opcode_ff) &&
      !guard_state.quad |=> quad_cmd_reject) // [R4]
      else $error("quad command not flagged without enable");

   chk_hold_sel_keep: assert property (s_wrsr and (opcode_ff == OP_WRSR3 && guard_state.quad)
      |=> $stable(guard_state.hold_sel)) // [R16]
      else $error("hold select changed in quad mode");

   chk_quad_pins: assert property (guard_state.quad |-> pins_as_data && !hold_pause) // [R3]
      else $error("control pin function active in quad mode");

   chk_quad_off_pins: assert property (!guard_state.quad |-> !pins_as_data) // [R2]
      else $error("pins left as data lines with quad off");

endmodule : status_reg_write_guard

/* File: hdl/guard_pkg.sv */
// Operation
// [R1] bit 1 quad enable, default 0
// [R2] quad off: pins keep control functions
// [R3] quad on: pins become data lines
// [R4] quad enable gates only six quad opcodes
// [R5] bit 0 upper protect bit, default 0
// [R6] protect 00: write allowed with latch set
// [R7] protect 01, pin low: writes refused
// [R8] protect 01, pin high: writes allowed
// [R9] protect 10: locked until reset
// [R10] protect 11, unlocked: locked until reset
// [R11] protect 11, locked: writes refused forever
// [R12] reset keeps 00 and 01 unchanged
// [R13] reset turns 10 into 00
// [R14] reset turns 11 unlocked into 01
// [R15] reset keeps 11 locked as 11
// [R16] hold/reset select writable only quad off
// [R17] refused write changes no state
package guard_pkg;

   // ************************************************************
   // command opcodes
   // ************************************************************
   localparam logic [7:0] OP_WRSR1 = 8'h01;     // write first status byte
   localparam logic [7:0] OP_WRSR2 = 8'h31;     // write quad/protect byte
   localparam logic [7:0] OP_WRSR3 = 8'h11;     // write third status byte
   localparam logic [7:0] OP_WRSR4 = 8'h71;     // write fourth status byte
   localparam logic [7:0] OP_WREN = 8'h06;      // set write enable latch
   localparam logic [7:0] OP_WRDI = 8'h04;      // clear write enable latch
   localparam logic [7:0] OP_SOFT_RST = 8'h99;  // software reset
   localparam logic [7:0] OP_QOUT_RD = 8'h6b;   // quad output read
   localparam logic [7:0] OP_XIP_RD = 8'heb;    // execute in place read
   localparam logic [7:0] OP_XIP_RD_DW = 8'he7; // execute in place read, word aligned
   localparam logic [7:0] OP_QPP = 8'h32;       // quad page program
   localparam logic [7:0] OP_BURST_WRAP = 8'h77; // set burst with wrap
   localparam logic [7:0] OP_QID_RD = 8'h94;    // quad id read

   // ************************************************************
   // field positions and frame bit counter values
   // ************************************************************
   localparam int QE_BIT = 1;        // quad enable in config byte
   localparam int SR_PROTECT_HI_BIT = 0;      // upper protect in config byte
   localparam int SR_PROTECT_LO_BIT = 7;      // lower protect in first status byte
   localparam int HOLD_SEL_BIT = 7;  // hold/reset select in third byte
   localparam logic [4:0] CMD_LAST = 5'h07;   // bit index ending opcode
   localparam logic [4:0] DATA_LAST = 5'h0f;  // bit index ending data byte
   localparam logic [4:0] CNT_MAX = 5'h10;    // counter saturation

   // ************************************************************
   // carriers
   // ************************************************************
   // volatile guard state
   typedef struct packed {
      logic lock;      // sr_permanent_lock copy
      logic sr_protect_hi;      // sr_protect_hi
      logic sr_protect_lo;      // sr_protect_lo
      logic quad;      // quad_io_enable
      logic hold_sel;  // 1 selects reset function on shared pin
      logic write_enable_latch;       // write_enable_latch
   } guard_state_s;

   // non-volatile copies presented by the array
   typedef struct packed {
      logic lock;
      logic sr_protect_hi;
      logic sr_protect_lo;
      logic quad;
      logic hold_sel;
   } nv_cfg_s;

   localparam guard_state_s GUARD_RST = '{default: 1'b0};

   // ************************************************************
   // decoders
   // ************************************************************
   // opcodes whose behaviour depends on quad enable
   function automatic logic is_quad_cmd(input logic [7:0] op);
      is_quad_cmd = (op == OP_QOUT_RD) || (op == OP_XIP_RD) || (op == OP_XIP_RD_DW) ||
                    (op == OP_QPP) || (op == OP_BURST_WRAP) || (op == OP_QID_RD);
   endfunction : is_quad_cmd

   // write status register opcodes
   function automatic logic is_wrsr(input logic [7:0] op);
      is_wrsr = (op == OP_WRSR1) || (op == OP_WRSR2) || (op == OP_WRSR3) || (op == OP_WRSR4);
   endfunction : is_wrsr

endpackage : guard_pkg

/* File: hdl/bit_sync.sv */
`timescale 1ns/100ps
// two flop synchroniser, first stage read only by second
module bit_sync
   import guard_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_ff; // first stage
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_dout;

   // next values
   always_comb
   begin
      nxt_meta = din;
      nxt_dout = meta_ff;
   end

   // registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         dout <= '0;
      end
      else
      begin
         meta_ff <= nxt_meta;
         dout <= nxt_dout;
      end
   end
endmodule : bit_sync

/* File: testbench/spi_host.sv */
`timescale 1ns/100ps
// ************************************************************
// serial host model
// ************************************************************
// link clock runs only inside a frame, 6 ns period
module spi_host (
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_mosi
);
   // idle levels at time zero
   initial
   begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // one frame of n bits, msb first, data set up before each rise
   task automatic frame(input logic [15:0] word, input int n);
      #1.7 spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         spi_mosi = word[15-i];
         #3 spi_clk = 1'b1;
         #3 spi_clk = 1'b0;
      end
      #3 spi_cs_n = 1'b1;
      // released line shows the inverse of its last bit
      spi_mosi = ~spi_mosi;
   endtask : frame
endmodule : spi_host

/* File: testbench/status_reg_write_guard_tb.sv */
`timescale 1ns/100ps
// ************************************************************
// bench for the status write guard
// ************************************************************
module status_reg_write_guard_tb
   import guard_pkg::*;
;
   logic core_clk, rst_n, wp_pin, hold_pin; // bench driven inputs
   logic spi_clk, spi_cs_n, spi_mosi;     // host model outputs
   nv_cfg_s nv_cfg;                       // non-volatile copies
   guard_state_s guard_state;             // observed state
   logic [7:0] cfg_byte;                  // observed config byte
   logic pins_as_data, hold_pause, write_reject, quad_cmd_reject;
   int n_fail, comparisons, n_wrej, n_qrej, w0; // counters
   logic [7:0] qops [7] = '{OP_QOUT_RD, OP_XIP_RD, OP_XIP_RD_DW, OP_QPP, OP_BURST_WRAP, OP_QID_RD, 8'h03};
   logic [2:0] nvs [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111}; // lock,sr_protect_hi,sr_protect_lo
   logic [2:0] exps [5] = '{3'b000, 3'b001, 3'b000, 3'b001, 3'b111};

   status_reg_write_guard i_dut (.core_clk(core_clk), .rst_n(rst_n), .spi_clk(spi_clk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_pin(wp_pin), .hold_pin(hold_pin),
      .nv_cfg(nv_cfg), .guard_state(guard_state), .quad_and_protect_config(cfg_byte),
      .pins_as_data(pins_as_data), .hold_pause(hold_pause), .write_reject(write_reject),
      .quad_cmd_reject(quad_cmd_reject));
   spi_host i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

   // core clock, 40 ns period
   always #20 core_clk = ~core_clk;

   // count one-cycle reject pulses, sampled mid-cycle where they are settled
   always @(negedge core_clk)
   begin
      if (write_reject === 1'b1) n_wrej++;
      if (quad_cmd_reject === 1'b1) n_qrej++;
   end

   // compare and report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one frame, then let the crossing settle
   task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
      i_host.frame({op, d}, n);
      repeat (8) @(negedge core_clk);
   endtask : cmd

   // latch set, then a write-status frame
   task automatic wr(input logic [7:0] op, input logic [7:0] d);
      cmd(OP_WREN, 8'h00, 8);
      cmd(op, d, 16);
   endtask : wr

   // write that must be refused with one pulse
   task automatic wr_refused(input logic [7:0] op, input logic [7:0] d);
      w0 = n_wrej;
      wr(op, d);
      check(8'(n_wrej - w0), 8'h01);
   endtask : wr_refused

   // whole state {lock,sr_protect_hi,sr_protect_lo,quad,hold_sel,wel}
   task automatic st(input logic [5:0] e);
      check({2'b00, guard_state}, {2'b00, e});
   endtask : st

   // hard reset pulse
   task automatic hard_rst;
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask : hard_rst

   // verdict and end of run
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   // hang guard
   initial
   begin
      #1ms;
      n_fail++;
      wrap_up();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      wp_pin = 1'b0;
      hold_pin = 1'b1;
      nv_cfg = '0;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      st(6'h00);
      check(cfg_byte, 8'h00);
      // latch set, then cleared again: the write must be refused
      cmd(OP_WREN, 8'h00, 8);
      st(6'b000001);
      cmd(OP_WRDI, 8'h00, 8);
      w0 = n_wrej;
      cmd(OP_WRSR2, 8'h02, 16);
      check(8'(n_wrej - w0), 8'h01);
      // fourth byte write is taken and only drops the latch
      w0 = n_wrej;
      wr(OP_WRSR4, 8'hff);
      check(8'(n_wrej - w0), 8'h00);
      st(6'h00);
      wr(OP_WRSR2, 8'h02);
      st(6'b000100);
      check(cfg_byte, 8'h02);
      check({7'h00, pins_as_data}, 8'h01);
      wr(OP_WRSR3, 8'h80);
      st(6'b000100);
      hold_pin = 1'b0;
      repeat (6) @(negedge core_clk);
      check({7'h00, hold_pause}, 8'h00);
      hold_pin = 1'b1;
      w0 = n_qrej;
      cmd(OP_QOUT_RD, 8'h00, 8);
      check(8'(n_qrej - w0), 8'h00);
      wr(OP_WRSR2, 8'h00);
      check({7'h00, pins_as_data}, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         w0 = n_qrej;
         cmd(qops[i], 8'h00, 8);
         check(8'(n_qrej - w0), (i < 6) ? 8'h01 : 8'h00);
      end
      hold_pin = 1'b0;
      repeat (6) @(negedge core_clk);
      check({7'h00, hold_pause}, 8'h01);
      hold_pin = 1'b1;
      repeat (6) @(negedge core_clk);
      wr(OP_WRSR3, 8'h80);
      st(6'b000010);
      // reset function: pin low reloads (latch dropped, stored select kept), never pauses
      nv_cfg.hold_sel = 1'b1;
      cmd(OP_WREN, 8'h00, 8);
      hold_pin = 1'b0;
      repeat (6) @(negedge core_clk);
      check({7'h00, hold_pause}, 8'h00);
      hold_pin = 1'b1;
      repeat (6) @(negedge core_clk);
      st(6'b000010);
      nv_cfg.hold_sel = 1'b0;
      wr(OP_WRSR3, 8'h00);
      st(6'b000000);
      wr(OP_WRSR1, 8'h80);
      st(6'b001000);
      wr_refused(OP_WRSR2, 8'h02);
      st(6'b001001);
      wp_pin = 1'b1;
      repeat (6) @(negedge core_clk);
      cmd(OP_WRSR2, 8'h01, 16);
      st(6'b011000);
      wr_refused(OP_WRSR2, 8'h00);
      st(6'b011001);
      cmd(OP_SOFT_RST, 8'h00, 8);
      st(6'b000000);
      wr(OP_WRSR2, 8'h01);
      st(6'b010000);
      wr_refused(OP_WRSR1, 8'h00);
      cmd(OP_SOFT_RST, 8'h00, 8);
      st(6'b000000);
      for (int i = 0; i < 5; i++)
      begin
         nv_cfg = '{lock: nvs[i][2], sr_protect_hi: nvs[i][1], sr_protect_lo: nvs[i][0], quad: 1'b0, hold_sel: 1'b0};
         hard_rst();
         check({5'h00, guard_state.lock, guard_state.sr_protect_hi, guard_state.sr_protect_lo}, {5'h00, exps[i]});
      end
      wr_refused(OP_WRSR2, 8'h00);
      cmd(OP_SOFT_RST, 8'h00, 8);
      st(6'b111000);
      wrap_up();
   end
endmodule : status_reg_write_guard_tb
